// ===== dcc_top.sv
// dual comparator control: registers, polarity, change interrupt, wake-up, pin controls
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`include "dcc_consts.svh"
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic       CORE_CLK,      // system clock, 10 MHz
    input  wire logic       RST,           // async reset, active high
    input  wire logic [7:0] ADDR,          // register index
    input  wire logic [7:0] WDATA,         // write data
    input  wire logic       WR,            // write strobe
    input  wire logic       RD,            // read strobe
    output logic      [7:0] RDATA,         // read data, cycle after RD
    input  wire logic [1:0] CMP_RAW,       // analog comparator outputs, async
    input  wire logic       CORE_SLEEP,    // core in sleep or idle mode
    output logic      [1:0] COMPARATOR_ON, // analog power enable per channel
    output logic      [1:0] HYSTERESIS_ON, // hysteresis enable per channel
    output logic      [1:0] PIN_OUT,       // result driven to shared pin
    output logic      [1:0] PIN_OE,        // shared pin output enable
    output logic      [1:0] PULLUP_OFF,    // force pull-highs off on inputs
    output logic      [1:0] PORT_RD_ZERO,  // port read forced to zero
    output logic            IRQ,           // level interrupt, unmasked flags
    output logic            WAKE_REQ       // wake-up request to core
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    dcc_bus_t   bus;
    dcc_ctrl_t  ctrl_ff [2];
    logic [1:0] result_ff;
    logic [1:0] sync_q;
    logic [1:0] nxt_result;
    logic [1:0] flag_ff;
    logic [1:0] mask_ff;
    logic [1:0] route_ff;
    logic [1:0] pctl_ff;
    logic [1:0] change;
    logic [1:0] flag_clr;
    logic [1:0] flag_set_wr;
    dcc_pwr_t   pwr_ff;

    assign bus.addr  = ADDR;
    assign bus.wdata = WDATA;
    assign bus.wr    = WR;
    assign bus.rd    = RD;

    // ----------------------------------------------------------------
    // per-channel datapath
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ch
            logic wr_ctrl;
            assign wr_ctrl = bus.wr && (bus.addr == (gi == 0 ? `DCC_OFS_CTRL0 : `DCC_OFS_CTRL1));

            dcc_sync u_sync (
                .CORE_CLK (CORE_CLK),
                .RST      (RST),
                .d_in     (CMP_RAW[gi]),
                .q_out    (sync_q[gi])
            );

            // result bit: forced low when off, inverted on request
            assign nxt_result[gi] = ctrl_ff[gi].on ? (sync_q[gi] ^ ctrl_ff[gi].inv) : 1'b0;
            // change on the internal bit only, regardless of pin routing
            assign change[gi] = nxt_result[gi] != result_ff[gi];

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    ctrl_ff[gi] <= '{on: 1'b0, inv: 1'b0, hys: 1'b1};
                end else if (wr_ctrl) begin
                    // only bits 6, 5 and 0 are writable
                    ctrl_ff[gi].on  <= bus.wdata[`DCC_BIT_ON];
                    ctrl_ff[gi].inv <= bus.wdata[`DCC_BIT_INV];
                    ctrl_ff[gi].hys <= bus.wdata[`DCC_BIT_HYS];
                end
            end

            // updates continue regardless of the sleep state
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    result_ff[gi] <= 1'b0;
                end else begin
                    result_ff[gi] <= nxt_result[gi];
                end
            end

            // flag: hardware set wins over software clear
            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    flag_ff[gi] <= 1'b0;
                end else if (change[gi] || flag_set_wr[gi]) begin
                    flag_ff[gi] <= 1'b1;
                end else if (flag_clr[gi]) begin
                    flag_ff[gi] <= 1'b0;
                end
            end

            always_ff @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    COMPARATOR_ON[gi] <= 1'b0;
                    HYSTERESIS_ON[gi] <= 1'b1;
                    PULLUP_OFF[gi]    <= 1'b0;
                    PIN_OUT[gi]       <= 1'b0;
                    PIN_OE[gi]        <= 1'b0;
                    PORT_RD_ZERO[gi]  <= 1'b0;
                end else begin
                    COMPARATOR_ON[gi] <= ctrl_ff[gi].on;
                    HYSTERESIS_ON[gi] <= ctrl_ff[gi].hys;
                    PULLUP_OFF[gi]    <= ctrl_ff[gi].on;
                    PIN_OUT[gi]       <= result_ff[gi];
                    PIN_OE[gi]        <= route_ff[gi] && ctrl_ff[gi].on;
                    // port logic muxes zero when set, else its own data
                    PORT_RD_ZERO[gi]  <= ctrl_ff[gi].on && pctl_ff[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt status, mask, routing
    // ----------------------------------------------------------------
    // write one clears; bits 7..6 of the status word let software preset flags
    assign flag_clr    = (bus.wr && bus.addr == `DCC_OFS_IRQ_STAT) ? bus.wdata[1:0] : 2'h0;
    assign flag_set_wr = (bus.wr && bus.addr == `DCC_OFS_IRQ_STAT) ? bus.wdata[7:6] : 2'h0;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            mask_ff <= `DCC_MASK_RST;
        end else if (bus.wr && bus.addr == `DCC_OFS_IRQ_MASK) begin
            mask_ff <= bus.wdata[1:0];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            route_ff <= 2'h0;
            pctl_ff  <= 2'h0;
        end else if (bus.wr && bus.addr == `DCC_OFS_PORT_CFG) begin
            route_ff <= bus.wdata[1:0];
            pctl_ff  <= bus.wdata[5:4];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(flag_ff & mask_ff);
        end
    end

    // ----------------------------------------------------------------
    // wake-up: a new flag rise while asleep on an enabled channel
    // ----------------------------------------------------------------
    // an already-set flag cannot rise again, which is how presetting blocks wake
    logic [1:0] rise;
    assign rise[0] = change[0] && !flag_ff[0] && ctrl_ff[0].on;
    assign rise[1] = change[1] && !flag_ff[1] && ctrl_ff[1].on;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pwr_ff <= DCC_AWAKE;
        end else begin
            case (pwr_ff)
                DCC_AWAKE:  pwr_ff <= CORE_SLEEP ? DCC_ASLEEP : DCC_AWAKE;
                DCC_ASLEEP: begin
                    if (!CORE_SLEEP) begin
                        pwr_ff <= DCC_AWAKE;
                    end else if (|rise) begin
                        pwr_ff <= DCC_WAKING;
                    end
                end
                DCC_WAKING: pwr_ff <= CORE_SLEEP ? DCC_WAKING : DCC_AWAKE;
                default:    pwr_ff <= DCC_AWAKE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            WAKE_REQ <= 1'b0;
        end else begin
            WAKE_REQ <= (pwr_ff == DCC_ASLEEP && CORE_SLEEP && |rise) || (pwr_ff == DCC_WAKING && CORE_SLEEP);
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    function automatic logic [7:0] ctrl_word(dcc_ctrl_t c, logic r);
        logic [7:0] w;
        w = 8'h00;
        w[`DCC_BIT_ON]  = c.on;
        w[`DCC_BIT_INV] = c.inv;
        w[`DCC_BIT_RES] = r;
        w[`DCC_BIT_HYS] = c.hys;
        return w;
    endfunction : ctrl_word

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                `DCC_OFS_CTRL0:    RDATA <= ctrl_word(ctrl_ff[0], result_ff[0]);
                `DCC_OFS_CTRL1:    RDATA <= ctrl_word(ctrl_ff[1], result_ff[1]);
                `DCC_OFS_IRQ_STAT: RDATA <= {6'h00, flag_ff};
                `DCC_OFS_IRQ_MASK: RDATA <= {6'h00, mask_ff};
                `DCC_OFS_SLEEP:    RDATA <= {6'h00, pwr_ff};
                `DCC_OFS_PORT_CFG: RDATA <= {2'h0, pctl_ff, 2'h0, route_ff};
                default:           RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule : dcc_top

// ===== dcc_consts.svh
// constants for the dual comparator control block
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH
// register offsets (8-bit index on the plain port)
`define DCC_OFS_CTRL0     8'h00
`define DCC_OFS_CTRL1     8'h01
`define DCC_OFS_IRQ_STAT  8'h02
`define DCC_OFS_IRQ_MASK  8'h03
`define DCC_OFS_SLEEP     8'h04
`define DCC_OFS_PORT_CFG  8'h05
// control register bit positions
`define DCC_BIT_ON        6
`define DCC_BIT_INV       5
`define DCC_BIT_RES       4
`define DCC_BIT_HYS       0
// reset values
`define DCC_CTRL_RST      8'h01
`define DCC_MASK_RST      2'h0
`define DCC_PORT_RST      8'h00
`endif

// ===== dcc_pkg.sv
// types for the dual comparator control block
package dcc_pkg;
    typedef struct packed {
        logic       on;
        logic       inv;
        logic       hys;
    } dcc_ctrl_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dcc_bus_t;
    typedef enum logic [1:0] {
        DCC_AWAKE  = 2'h0,
        DCC_ASLEEP = 2'h1,
        DCC_WAKING = 2'h3
    } dcc_pwr_t;
endpackage : dcc_pkg

// ===== dcc_sync.sv
// three-stage synchroniser with agreement filter for one comparator output
`timescale 1ns/10ps
module dcc_sync (
    input  wire logic CORE_CLK, // system clock
    input  wire logic RST,      // async reset, active high
    input  wire logic d_in,     // asynchronous level
    output logic      q_out     // settled level
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            q_out <= 1'b0;
        end else begin
            s1_ff <= d_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // only update once stages two and three agree
            if (s2_ff == s3_ff) begin
                q_out <= s3_ff;
            end
        end
    end
endmodule : dcc_sync

// ===== dcc_cmp_model.sv
// behavioural model of the two analog comparators in front of the block
`timescale 1ns/10ps
module dcc_cmp_model (
    input  wire logic       core_clk, // system clock, paces the idle pattern
    input  wire logic [1:0] pos_gt,   // 1: positive input above negative
    input  wire logic [1:0] powered,  // analog power per channel
    output logic      [1:0] raw       // comparator outputs, asynchronous
);
    logic [1:0] junk_ff = 2'h0;
    // ----------------------------------------
    // unpowered channel shows no stable level
    // ----------------------------------------
    always @(posedge core_clk) begin
        junk_ff <= ~junk_ff;
    end
    // skewed off the clock so the synchroniser sees a true async edge
    assign #7 raw = (powered & pos_gt) | (~powered & junk_ff);
endmodule : dcc_cmp_model

// ===== dcc_top_asserts.sv
// port-level concurrent checks for the dual comparator control block
`timescale 1ns/10ps
module dcc_chk (
    input wire logic       CORE_CLK,      // system clock
    input wire logic       RST,           // async reset
    input wire logic [7:0] ADDR,          // register index
    input wire logic [7:0] WDATA,         // write data
    input wire logic       WR,            // write strobe
    input wire logic       RD,            // read strobe
    input wire logic [7:0] RDATA,         // read data
    input wire logic       CORE_SLEEP,    // sleep or idle
    input wire logic [1:0] COMPARATOR_ON, // channel enables
    input wire logic [1:0] HYSTERESIS_ON, // hysteresis enables
    input wire logic [1:0] PIN_OUT,       // pin level
    input wire logic [1:0] PIN_OE,        // pin enable
    input wire logic [1:0] PULLUP_OFF,    // pull-high disconnect
    input wire logic [1:0] PORT_RD_ZERO,  // port read zeroed
    input wire logic       WAKE_REQ       // wake-up request
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence off_held_s;
        !COMPARATOR_ON[0] [*3];
    endsequence
    pullup_follow_a: assert property (PULLUP_OFF == COMPARATOR_ON) else $error("pull-high not tied to enable");
    port_zero_a: assert property ((PORT_RD_ZERO & ~COMPARATOR_ON) == 2'h0) else $error("port zeroed while off");
    pin_route_a: assert property ((PIN_OE & ~COMPARATOR_ON) == 2'h0) else $error("pin driven while off");
    read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data outside slot");
    // enable and hysteresis outputs are re-registered from the control word, so they trail a write by two edges
    ctrl_on_a: assert property (WR && ADDR == 8'h00 |=> ##1 COMPARATOR_ON[0] == $past(WDATA[6], 2)) else $error("enable bit");
    hys_wr_a: assert property (WR && ADDR == 8'h01 |=> ##1 HYSTERESIS_ON[1] == $past(WDATA[0], 2)) else $error("hysteresis bit");
    wake_drop_a: assert property (WAKE_REQ && !CORE_SLEEP |=> !WAKE_REQ) else $error("wake held while awake");
    off_pin_a: assert property (off_held_s |-> !PIN_OUT[0]) else $error("result high while off");
endmodule : dcc_chk
bind dcc_top dcc_chk u_chk (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CORE_SLEEP(CORE_SLEEP), .COMPARATOR_ON(COMPARATOR_ON), .HYSTERESIS_ON(HYSTERESIS_ON),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PULLUP_OFF(PULLUP_OFF), .PORT_RD_ZERO(PORT_RD_ZERO), .WAKE_REQ(WAKE_REQ));

// ===== dual_comparator_control_tb.sv
// self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module dual_comparator_control_tb;
    import dcc_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } dcc_row_t;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       wr       = 1'b0;
    logic       rd       = 1'b0;
    logic       sleep    = 1'b0;
    logic [1:0] pos_gt   = 2'h0;
    logic [7:0] rdata, got;
    logic [1:0] raw, on, hys, pout, poe, puoff, pzero;
    logic       irq, wake;
    int         failures = 0;
    int         n_checks = 0;
    dcc_row_t   rows [6] = '{'{8'h00, 8'hFF, 8'h71}, '{8'h00, 8'h00, 8'h00}, '{8'h01, 8'h41, 8'h41},
                             '{8'h01, 8'h20, 8'h20}, '{8'h03, 8'hFF, 8'h03}, '{8'h07, 8'hFF, 8'h00}};
    always #50 core_clk = ~core_clk;
    dcc_cmp_model u_cmp (.core_clk(core_clk), .pos_gt(pos_gt), .powered(on), .raw(raw));
    dcc_top dut (.CORE_CLK(core_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CMP_RAW(raw), .CORE_SLEEP(sleep), .COMPARATOR_ON(on), .HYSTERESIS_ON(hys), .PIN_OUT(pout), .PIN_OE(poe),
        .PULLUP_OFF(puoff), .PORT_RD_ZERO(pzero), .IRQ(irq), .WAKE_REQ(wake));
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 got = rdata;
    endtask : rd_reg
    task automatic test_done;
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        #200000;
        failures++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rd_reg(8'h00);
        chk(got, 8'h01);
        rd_reg(8'h01);
        chk(got, 8'h01);
        chk({6'h0, hys}, 8'h03);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            repeat (8) @(posedge core_clk);
            rd_reg(rows[i].a);
            chk(got, rows[i].e);
        end
        wr_reg(8'h00, 8'h00);
        wr_reg(8'h02, 8'h03);
        wr_reg(8'h03, 8'h01);
        wr_reg(8'h00, 8'h40);
        repeat (8) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        pos_gt <= 2'h1;
        repeat (8) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        rd_reg(8'h02);
        chk(got, 8'h01);
        rd_reg(8'h00);
        chk(got, 8'h50);
        wr_reg(8'h02, 8'h01);
        repeat (2) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        wr_reg(8'h01, 8'h40);
        pos_gt <= 2'h3;
        repeat (8) @(posedge core_clk);
        rd_reg(8'h02);
        chk(got, 8'h02);
        chk({7'h0, irq}, 8'h00);
        wr_reg(8'h02, 8'h03);
        sleep  <= 1'b1;
        pos_gt <= 2'h0;
        repeat (8) @(posedge core_clk);
        chk({7'h0, wake}, 8'h01);
        rd_reg(8'h00);
        chk(got, 8'h40);
        sleep <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({7'h0, wake}, 8'h00);
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h02, 8'h03);
        wr_reg(8'h02, 8'h40);
        sleep  <= 1'b1;
        pos_gt <= 2'h1;
        repeat (8) @(posedge core_clk);
        chk({7'h0, wake}, 8'h00);
        sleep <= 1'b0;
        wr_reg(8'h05, 8'h11);
        repeat (3) @(posedge core_clk);
        chk({pout, poe, puoff, pzero}, 8'h55);
        wr_reg(8'h00, 8'h60);
        repeat (8) @(posedge core_clk);
        rd_reg(8'h00);
        chk(got, 8'h60);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd_reg(8'h00);
        chk(got, 8'h01);
        chk({on, poe, puoff, pzero}, 8'h00);
        test_done;
    end
endmodule : dual_comparator_control_tb
